/* core/efs_top.sv */
// Event flow sequencer: hit and road state machines with APB registers
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module efs_top
(
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Hit distribution chip
  input  wire logic                          hit_end_event,
  input  wire logic [efs_pkg::EFS_AUX_W-1:0] hit_aux_in,
  // Road readout chip
  input  wire logic                          road_end_event,
  output logic                               road_go,
  // Board wide controls
  output logic                               event_restart,
  output logic                               init_out,
  output logic                               tmode_out,
  output logic                               freeze_out,
  output logic      [efs_pkg::EFS_AUX_W-1:0] aux_out
);
  import efs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [EFS_CTRL_W-1:0] ctrl;            // Init, test mode, freeze, freeze-on-error
  logic [EFS_CTRL_W-1:0] next_ctrl;
  logic [EFS_WAIT_W-1:0] hit_wait;        // Event switch wait length
  logic [EFS_WAIT_W-1:0] next_hit_wait;
  logic [EFS_WAIT_W-1:0] road_wait;       // Readout wait length
  logic [EFS_WAIT_W-1:0] next_road_wait;
  logic [EFS_ERR_W-1:0]  err;             // Sticky protocol errors
  logic [EFS_ERR_W-1:0]  next_err;
  logic [31:0]           next_prdata;
  logic                  next_pready;
  logic                  next_pslverr;
  logic                  wr_en;           // Write takes effect this edge
  logic                  mapped;          // Address hits a register

  efs_hit_e              hit_st;          // Hit loading machine
  efs_hit_e              next_hit_st;
  efs_road_e             road_st;         // Road readout machine
  efs_road_e             next_road_st;
  logic                  hit_eoe_pend;    // Hit end-event seen, not yet used
  logic                  next_hit_eoe_pend;
  logic [EFS_ID_W-1:0]   event_id;        // Identifier of the current event
  logic [EFS_ID_W-1:0]   next_event_id;
  logic                  hit_done;        // Switch wait over
  logic                  road_done;       // Readout wait over
  logic                  enter_switch;
  logic                  enter_rwait;
  logic                  init_now;
  logic [EFS_WAIT_W-1:0] rwait_cnt, next_rwait_cnt;  // Checker helper: cycles in readout wait
  logic [EFS_WAIT_W-1:0] rwait_len, next_rwait_len;  // Checker helper: wait length at entry

  ////////////////////////////////////////////////////////////////////////////////
  // APB register file

  // A write lands only on the edge where the access phase completes
  assign wr_en  = psel && penable && pready && pwrite;
  assign mapped = (paddr == EFS_OFS_CTRL) || (paddr == EFS_OFS_HIT_WAIT) ||
                  (paddr == EFS_OFS_ROAD_WAIT) || (paddr == EFS_OFS_STATUS) ||
                  (paddr == EFS_OFS_EVENT_ID) || (paddr == EFS_OFS_ERROR);

  // Next register contents and bus answer
  always_comb
  begin
    next_ctrl      = ctrl;
    next_hit_wait  = hit_wait;
    next_road_wait = road_wait;
    next_err       = err;
    next_prdata    = prdata;
    // Answer one cycle after setup: one wait-free access phase
    next_pready    = psel && !penable;
    next_pslverr   = psel && !penable && !mapped;
    if (wr_en)
    begin
      case (paddr)
        EFS_OFS_CTRL:      next_ctrl = pwdata[EFS_CTRL_W-1:0];
        EFS_OFS_HIT_WAIT:  next_hit_wait = pwdata[EFS_WAIT_W-1:0];
        EFS_OFS_ROAD_WAIT: next_road_wait = pwdata[EFS_WAIT_W-1:0];
        EFS_OFS_ERROR:     next_err = err & ~pwdata[EFS_ERR_W-1:0];
        default:           next_err = err;
      endcase
    end
    // Hardware set wins over a same-cycle software clear
    if (hit_end_event && hit_st != EFS_H_LOAD)
      next_err[EFS_ERR_HIT_EOE] = 1'b1;
    if (road_end_event && road_st != EFS_R_SEND)
      next_err[EFS_ERR_ROAD_EOE] = 1'b1;
    // Read data prepared in setup so it stands through the access phase
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        EFS_OFS_CTRL:      next_prdata = {{(32-EFS_CTRL_W){1'b0}}, ctrl};
        EFS_OFS_HIT_WAIT:  next_prdata = {{(32-EFS_WAIT_W){1'b0}}, hit_wait};
        EFS_OFS_ROAD_WAIT: next_prdata = {{(32-EFS_WAIT_W){1'b0}}, road_wait};
        EFS_OFS_STATUS:
        begin
          next_prdata = 32'h0000_0000;
          next_prdata[EFS_STAT_HIT_LSB +: 2]  = hit_st;
          next_prdata[EFS_STAT_ROAD_LSB +: 2] = road_st;
          next_prdata[EFS_STAT_FRZ_BIT]       = freeze_out;
        end
        EFS_OFS_EVENT_ID:  next_prdata = {{(32-EFS_ID_W){1'b0}}, event_id};
        EFS_OFS_ERROR:     next_prdata = {{(32-EFS_ERR_W){1'b0}}, err};
        default:           next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ctrl      <= EFS_CTRL_RST;
      hit_wait  <= EFS_WAIT_RST;
      road_wait <= EFS_WAIT_RST;
      err       <= '0;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end
    else
    begin
      ctrl      <= next_ctrl;
      hit_wait  <= next_hit_wait;
      road_wait <= next_road_wait;
      err       <= next_err;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wait timers

  // Each timer is loaded on entry to its waiting state
  efs_wait_timer u_hit_timer
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .load    (enter_switch),
    .len     (hit_wait),
    .done    (hit_done)
  );

  efs_wait_timer u_road_timer
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .load    (enter_rwait),
    .len     (road_wait),
    .done    (road_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Event sequencing

  assign init_now = ctrl[EFS_CTRL_INIT_BIT];

  // Both machines computed together since each looks at the other
  always_comb
  begin
    next_hit_st       = hit_st;
    next_road_st      = road_st;
    next_event_id     = event_id;
    // Remember the end-event so a busy readout does not lose it
    next_hit_eoe_pend = hit_eoe_pend || hit_end_event;
    enter_switch      = 1'b0;
    enter_rwait       = 1'b0;
    if (init_now)
    begin
      next_hit_st       = EFS_H_INIT;
      next_road_st      = EFS_R_INIT;
      next_hit_eoe_pend = 1'b0;
    end
    else
    begin
      // Hit loading machine
      case (hit_st)
        EFS_H_INIT:   next_hit_st = EFS_H_LOAD;
        EFS_H_LOAD:
        begin
          // Leave only with the event complete and the readout idle
          if (next_hit_eoe_pend && road_st == EFS_R_IDLE)
          begin
            next_hit_st       = EFS_H_SWITCH;
            enter_switch      = 1'b1;
            next_hit_eoe_pend = 1'b0;
            next_event_id     = hit_aux_in[EFS_ID_W-1:0];
          end
        end
        EFS_H_SWITCH:
        begin
          if (hit_done)
            next_hit_st = EFS_H_LOAD;
        end
        default:      next_hit_st = EFS_H_INIT;
      endcase
      // Road readout machine
      case (road_st)
        EFS_R_INIT:   next_road_st = EFS_R_IDLE;
        EFS_R_IDLE:
        begin
          // Start together with the event switch, one event behind
          if (enter_switch)
            next_road_st = EFS_R_SEND;
        end
        EFS_R_SEND:
        begin
          // The road chip signals when all roads are forwarded
          if (road_end_event)
          begin
            next_road_st = EFS_R_WAIT;
            enter_rwait  = 1'b1;
          end
        end
        EFS_R_WAIT:
        begin
          if (road_done)
            next_road_st = EFS_R_IDLE;
        end
        default:      next_road_st = EFS_R_INIT;
      endcase
    end
  end

  // Sequencer flops and registered outputs
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      hit_st        <= EFS_H_INIT;
      road_st       <= EFS_R_INIT;
      hit_eoe_pend  <= 1'b0;
      event_id      <= EFS_ID_RST;
      event_restart <= 1'b0;
      road_go       <= 1'b0;
      init_out      <= 1'b1;
      tmode_out     <= 1'b0;
      freeze_out    <= 1'b0;
      aux_out       <= '0;
    end
    else
    begin
      hit_st        <= next_hit_st;
      road_st       <= next_road_st;
      hit_eoe_pend  <= next_hit_eoe_pend;
      event_id      <= next_event_id;
      // One-cycle restart on the first cycle of the event switch
      event_restart <= enter_switch;
      // Readout-go stands for exactly the sending state
      road_go       <= (next_road_st == EFS_R_SEND);
      init_out      <= next_ctrl[EFS_CTRL_INIT_BIT];
      tmode_out     <= next_ctrl[EFS_CTRL_TMODE_BIT];
      // Freeze is decided here only: by software or on an error
      freeze_out    <= next_ctrl[EFS_CTRL_FREEZE_BIT] ||
                       (next_ctrl[EFS_CTRL_FRZERR_BIT] && (next_err != '0));
      // Spare bus: errors in the upper half, event id in the lower
      aux_out       <= {{(EFS_AUX_W-EFS_ID_W-EFS_ERR_W){1'b0}}, next_err,
                        next_event_id};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_init_holds_fsm: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(init_now) |-> (hit_st == EFS_H_INIT && road_st == EFS_R_INIT))
    else $error("state machines not held in init");

  a_release_advance: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (hit_st == EFS_H_INIT && !init_now) |=> (hit_st == EFS_H_LOAD && road_st == EFS_R_IDLE))
    else $error("machines did not advance after init release");

  a_switch_needs_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (hit_st == EFS_H_LOAD && !init_now ##1 hit_st == EFS_H_SWITCH)
      |-> $past(road_st) == EFS_R_IDLE)
    else $error("event switch entered with readout busy");

  a_restart_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(hit_st == EFS_H_SWITCH) |-> event_restart ##1 !event_restart)
    else $error("restart not a single pulse on switch entry");

  a_switch_length: assert property (@(posedge clk_sys) disable iff (sys_rst || init_now)
    ($rose(hit_st == EFS_H_SWITCH) && hit_wait == 16'h0000) |=> hit_st == EFS_H_LOAD)
    else $error("zero wait switch did not last one cycle");

  a_road_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(hit_st == EFS_H_SWITCH) |-> road_st == EFS_R_SEND)
    else $error("readout not sending with event switch");

  a_road_go_state: assert property (@(posedge clk_sys) disable iff (sys_rst)
    road_go == (road_st == EFS_R_SEND))
    else $error("readout-go does not match sending state");

  // Checker helper: a wait of up to 65536 cycles is counted here, not unrolled in a property
  always_comb
  begin
    next_rwait_len = enter_rwait ? road_wait : rwait_len;
    next_rwait_cnt = (road_st == EFS_R_WAIT) ? rwait_cnt + 1'b1 : '0;
  end
  always_ff @(posedge clk_sys)
  begin
    rwait_cnt <= sys_rst ? '0 : next_rwait_cnt;
    rwait_len <= sys_rst ? '0 : next_rwait_len;
  end

  a_road_wait_entry: assert property(@(posedge clk_sys) disable iff (sys_rst || init_now)
    (road_st == EFS_R_SEND && road_end_event) |=> road_st == EFS_R_WAIT)
    else $error("readout wait not entered");

  a_road_wait_len: assert property (@(posedge clk_sys) disable iff (sys_rst || init_now)
    road_st == EFS_R_WAIT |=> (road_st == EFS_R_IDLE) == ($past(rwait_cnt) == rwait_len))
    else $error("readout wait length not kept");

  a_idle_no_send: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (road_st == EFS_R_IDLE && hit_st != EFS_H_SWITCH ##1 road_st == EFS_R_SEND)
      |-> hit_st == EFS_H_SWITCH)
    else $error("readout left idle without a loaded event");

  a_freeze_sw: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ctrl[EFS_CTRL_FREEZE_BIT] |-> freeze_out)
    else $error("software freeze not driven");

  a_relay_tmode: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (tmode_out == ctrl[EFS_CTRL_TMODE_BIT]) && (init_out == ctrl[EFS_CTRL_INIT_BIT]))
    else $error("init or test mode not relayed");

  a_aux_event_id: assert property (@(posedge clk_sys) disable iff (sys_rst)
    aux_out[EFS_ID_W-1:0] == event_id)
    else $error("spare bus does not carry event id");
endmodule // efs_top

/* core/efs_pkg.sv */
// Shared constants and types of the event flow sequencer
package efs_pkg;
  // Register byte offsets on the APB bus
  localparam logic [11:0] EFS_OFS_CTRL      = 12'h000;
  localparam logic [11:0] EFS_OFS_HIT_WAIT  = 12'h004;
  localparam logic [11:0] EFS_OFS_ROAD_WAIT = 12'h008;
  localparam logic [11:0] EFS_OFS_STATUS    = 12'h00C;
  localparam logic [11:0] EFS_OFS_EVENT_ID  = 12'h010;
  localparam logic [11:0] EFS_OFS_ERROR     = 12'h014;
  // Control register field positions
  localparam int EFS_CTRL_INIT_BIT   = 0;
  localparam int EFS_CTRL_TMODE_BIT  = 1;
  localparam int EFS_CTRL_FREEZE_BIT = 2;
  localparam int EFS_CTRL_FRZERR_BIT = 3;
  localparam int EFS_CTRL_W          = 4;
  // Status register field positions
  localparam int EFS_STAT_HIT_LSB  = 0;
  localparam int EFS_STAT_ROAD_LSB = 4;
  localparam int EFS_STAT_FRZ_BIT  = 8;
  // Error flag positions
  localparam int EFS_ERR_HIT_EOE  = 0;
  localparam int EFS_ERR_ROAD_EOE = 1;
  localparam int EFS_ERR_W        = 2;
  // Widths
  localparam int EFS_WAIT_W = 16;
  localparam int EFS_ID_W   = 16;
  localparam int EFS_AUX_W  = 32;
  // Reset values: init held after reset so software releases the flow
  localparam logic [EFS_CTRL_W-1:0] EFS_CTRL_RST = 4'h1;
  localparam logic [EFS_WAIT_W-1:0] EFS_WAIT_RST = 16'h0004;
  localparam logic [EFS_ID_W-1:0]   EFS_ID_RST   = 16'h0000;
  // Hit loading state machine
  typedef enum logic [1:0] {
    EFS_H_INIT   = 2'b00,
    EFS_H_LOAD   = 2'b01,
    EFS_H_SWITCH = 2'b10
  } efs_hit_e;
  // Road readout state machine
  typedef enum logic [1:0] {
    EFS_R_INIT = 2'b00,
    EFS_R_IDLE = 2'b01,
    EFS_R_SEND = 2'b10,
    EFS_R_WAIT = 2'b11
  } efs_road_e;
endpackage

/* core/efs_wait_timer.sv */
// Programmable wait counter: a stay of len+1 cycles after a load
`timescale 1ns/10ps
module efs_wait_timer
(
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  // Control
  input  wire logic                          load,
  input  wire logic [efs_pkg::EFS_WAIT_W-1:0] len,
  // Result
  output logic                               done
);
  import efs_pkg::*;

  logic [EFS_WAIT_W-1:0] cnt;       // Remaining cycles
  logic [EFS_WAIT_W-1:0] next_cnt;  // Next count

  // Load on entry, then count down and stop at zero
  always_comb
  begin
    next_cnt = cnt;
    if (load)
      next_cnt = len;
    else if (cnt != '0)
      next_cnt = cnt - 1'b1;
  end

  // Count register
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  // Zero count means the stay is over; a zero length gives one cycle
  assign done = (cnt == '0);
endmodule // efs_wait_timer

/* tb/efs_chip_model.sv */
// Behavioural model of the hit and road chips around the sequencer
`timescale 1ns/10ps
module efs_chip_model
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Commands from the bench
  input  wire logic        hit_cmd,
  input  wire logic [15:0] hit_id,
  input  wire logic [7:0]  road_dly,
  input  wire logic        road_stray,
  // Sequencer side
  input  wire logic        road_go,
  output logic             hit_end_event,
  output logic [31:0]      hit_aux_in,
  output logic             road_end_event
);
  logic [7:0] cnt; // Cycles spent gathering roads

  //////////////////////////////////////////////////////////////////
  // Hit chip: end of loading, new event id held on the spare bus
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      hit_end_event <= 1'b0;
      hit_aux_in    <= 32'h00000000;
    end
    else
    begin
      hit_end_event <= hit_cmd;
      if (hit_cmd)
        hit_aux_in <= {16'h0000, hit_id};
    end
  end

  //////////////////////////////////////////////////////////////////
  // Road chip: gathers for road_dly+1 cycles, then one end pulse
  // A stray pulse is only sent when the bench asks for it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !road_go)
      cnt <= 8'h00;
    else
      cnt <= cnt + 8'h01;
    road_end_event <= road_stray || (!sys_rst && road_go && cnt == road_dly);
  end
endmodule // efs_chip_model

/* tb/efs_top_tb.sv */
// Self-checking bench of the event flow sequencer
`timescale 1ns/10ps
module efs_top_tb;
  import efs_pkg::*;
  // Design and model wiring
  logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, hit_aux_in, aux_out;
  logic        hit_end_event, road_end_event, road_go, event_restart;
  logic        init_out, tmode_out, freeze_out;
  // Model commands
  logic        hit_cmd, road_stray;
  logic [15:0] hit_id;
  logic [7:0]  road_dly;
  // Score keeping
  int          err_total, cmp_count;

  efs_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hit_end_event(hit_end_event), .hit_aux_in(hit_aux_in),
    .road_end_event(road_end_event), .road_go(road_go), .event_restart(event_restart),
    .init_out(init_out), .tmode_out(tmode_out), .freeze_out(freeze_out), .aux_out(aux_out));

  efs_chip_model chips (.clk_sys(clk_sys), .sys_rst(sys_rst), .hit_cmd(hit_cmd),
    .hit_id(hit_id), .road_dly(road_dly), .road_stray(road_stray), .road_go(road_go),
    .hit_end_event(hit_end_event), .hit_aux_in(hit_aux_in), .road_end_event(road_end_event));

  //////////////////////////////////////////////////////////////////
  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the watchdog may end this wait
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask

  // Let a register write reach the outputs
  task automatic settle();
    repeat (3) @(posedge clk_sys);
  endtask

  // Hit chip end of loading: a one-cycle command launched at the current edge
  task automatic fire(input logic [15:0] id);
    hit_cmd <= 1'b1;
    hit_id  <= id;
    @(posedge clk_sys);
    hit_cmd <= 1'b0;
  endtask

  // Edges until restart is seen high, bounded
  task automatic wait_rst(output int n);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (event_restart !== 1'b1 && n < 100);
    // A restart that never comes ends the run as a failure
    if (event_restart !== 1'b1)
    begin
      err_total++;
      wrap_up();
    end
  endtask

  // Edges until readout-go is seen low, bounded
  task automatic wait_low(output int n);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (road_go !== 1'b0 && n < 100);
    // A readout that never ends the run as a failure
    if (road_go !== 1'b0)
    begin
      err_total++;
      wrap_up();
    end
  endtask

  //////////////////////////////////////////////////////////////////
  // Reset values, relay levels and an unmapped access
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    chk(init_out, 32'h1);
    chk({tmode_out, freeze_out, road_go}, 32'h0);
    chk(aux_out, 32'h0);
    rd(EFS_OFS_CTRL, 32'(EFS_CTRL_RST));
    rd(EFS_OFS_HIT_WAIT, 32'(EFS_WAIT_RST));
    rd(EFS_OFS_ROAD_WAIT, 32'(EFS_WAIT_RST));
    repeat (10) @(posedge clk_sys);
    rd(EFS_OFS_STATUS, 32'h0);
    rd(EFS_OFS_EVENT_ID, 32'h0);
    apb(1'b0, 12'h018, 32'h0, q, e);
    chk(e, 32'h1);
    chk(q, 32'h0);
    $display("reset test done");
  endtask

  // Init release and test-mode relay
  task automatic t_release();
    wr(EFS_OFS_CTRL, 32'h2);
    settle();
    chk({init_out, tmode_out}, 32'h1);
    rd(EFS_OFS_STATUS, 32'h11);
    wr(EFS_OFS_CTRL, 32'h0);
    $display("release test done");
  endtask

  // Two events overlapping, zero road wait
  task automatic t_event();
    int n;
    wr(EFS_OFS_HIT_WAIT, 32'h0);
    wr(EFS_OFS_ROAD_WAIT, 32'h0);
    road_dly <= 8'd5;
    fire(16'h1234);
    wait_rst(n);
    chk(road_go, 32'h1);
    chk(aux_out, 32'h1234);
    fire(16'h5678);
    wait_low(n);
    chk(n, 32'd6);
    wait_rst(n);
    chk(n, 32'd2);
    chk(aux_out, 32'h5678);
    wait_low(n);
    rd(EFS_OFS_EVENT_ID, 32'h5678);
    rd(EFS_OFS_ERROR, 32'h0);
    $display("event test done");
  endtask

  // Switch length, early end-event, errors and freeze
  task automatic t_switch();
    int n;
    wr(EFS_OFS_HIT_WAIT, 32'h6);
    road_dly <= 8'd0;
    fire(16'h0001);
    wait_rst(n);
    fire(16'h0002);
    wait_rst(n);
    chk(n, 32'd7);
    repeat (12) @(posedge clk_sys);
    rd(EFS_OFS_ERROR, 32'h1);
    rd(EFS_OFS_EVENT_ID, 32'h2);
    wr(EFS_OFS_CTRL, 32'h8);
    settle();
    chk(freeze_out, 32'h1);
    chk(aux_out, 32'h10002);
    wr(EFS_OFS_ERROR, 32'h1);
    settle();
    chk(freeze_out, 32'h0);
    road_stray <= 1'b1;
    @(posedge clk_sys);
    road_stray <= 1'b0;
    rd(EFS_OFS_ERROR, 32'h2);
    wr(EFS_OFS_ERROR, 32'h3);
    wr(EFS_OFS_CTRL, 32'h4);
    settle();
    rd(EFS_OFS_STATUS, 32'h111);
    $display("switch test done");
  endtask

  //////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    clk_sys = 1'b0; sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; hit_cmd = 1'b0; hit_id = 16'h0;
    road_dly = 8'h00; road_stray = 1'b0; err_total = 0; cmp_count = 0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_release();
    t_event();
    t_switch();
    wrap_up();
  end

  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    #(25 * 5000);
    err_total++;
    wrap_up();
  end
endmodule // efs_top_tb
